// ### include/see_pkg.sv
// Package of constants and types for the serial EEPROM access core
`default_nettype none
package see_pkg;
    // Array size and address widths, largest configuration
    localparam int SEE_ARRAY_BITS = 16384;
    localparam int SEE_WORD_ADDR_W = 10;
    localparam int SEE_BYTE_ADDR_W = 11;
    localparam int SEE_WORD_W = 16;
    localparam int SEE_BYTE_W = 8;
    // Opcodes carried after the start bit
    localparam logic [1:0] SEE_OP_EXT = 2'h0;
    localparam logic [1:0] SEE_OP_WRITE = 2'h1;
    localparam logic [1:0] SEE_OP_READ = 2'h2;
    localparam logic [1:0] SEE_OP_ERASE = 2'h3;
    // Extended codes taken from the top two address bits
    localparam logic [1:0] SEE_EXT_LOCK = 2'h0;
    localparam logic [1:0] SEE_EXT_FILL = 2'h1;
    localparam logic [1:0] SEE_EXT_BULK_ERASE = 2'h2;
    localparam logic [1:0] SEE_EXT_UNLOCK = 2'h3;
    // Erased cell value
    localparam logic [15:0] SEE_ERASED = 16'hFFFF;
    // Programming time and its count at 20 MHz
    localparam int SEE_CLK_HZ = 20_000_000;
    localparam int SEE_PROG_TIME_US = 5000;
    localparam int SEE_PROG_CYCLES = SEE_PROG_TIME_US * (SEE_CLK_HZ / 1_000_000);
    // Sequencer states
    typedef enum logic [2:0] {
        SEE_IDLE = 3'b000,
        SEE_OPCODE = 3'b001,
        SEE_ADDR = 3'b010,
        SEE_DATA = 3'b011,
        SEE_READ = 3'b100,
        SEE_WAIT = 3'b101
    } see_state_t;
endpackage : see_pkg
`default_nettype wire

// ### hdl/see_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module see_sync
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed
    {
        logic [2:0] stage;
        logic level;
    } see_sync_st_t;

    see_sync_st_t st_reg;
    see_sync_st_t st_next;

    ////////////////////////////////////////////////////////////////
    // Level changes once stages two and three agree
    always_comb
    begin
        st_next = st_reg;
        st_next.stage = {st_reg.stage[1:0], i_pin};
        if (st_reg.stage[1] == st_reg.stage[2])
        begin
            st_next.level = st_reg.stage[2];
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_level = st_reg.level;
endmodule : see_sync
`default_nettype wire

// ### hdl/see_core.sv
// Serial EEPROM access core: instruction decoder, array and programmer
`timescale 1ns/100ps
`default_nettype none
module see_core
    import see_pkg::*;
#(
    parameter int ARRAY_BITS = see_pkg::SEE_ARRAY_BITS,
    parameter int PROG_CYCLES = see_pkg::SEE_PROG_CYCLES
)
(
    // Clock and power-on reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Serial pins
    input wire logic i_select,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_width_select,
    output logic o_sdata,
    output logic o_sdata_oe,
    // Status
    output logic o_busy
);
    import see_pkg::*;

    localparam int BYTES = ARRAY_BITS / 8;
    localparam int BAW = $clog2(BYTES);
    localparam int WAW = BAW - 1;
    localparam int PCW = $clog2(PROG_CYCLES + 1);

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic sel_s;
    logic clk_s;
    logic din_s;
    logic wsel_s;

    see_sync u_sync_sel (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_pin(i_select), .o_level(sel_s));
    see_sync u_sync_clk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_pin(i_sclk), .o_level(clk_s));
    see_sync u_sync_din (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_pin(i_sdata), .o_level(din_s));
    see_sync u_sync_wsel (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_pin(i_width_select), .o_level(wsel_s));

    ////////////////////////////////////////////////////////////////
    // Byte array; a word is the byte pair {2n+1, 2n}
    logic [7:0] mem_reg [BYTES];

    // Bit count of the address field for the present organisation
    function automatic logic [4:0] addr_len(input logic words);
        addr_len = words ? 5'(WAW) : 5'(BAW);
    endfunction : addr_len

    // Reads one location, word or byte, by index
    function automatic logic [15:0] fetch(input logic words,
                                          input logic [BAW-1:0] a);
        logic [BAW-1:0] lo;
        lo = words ? {a[BAW-2:0], 1'b0} : a;
        fetch = words ? {mem_reg[lo + 1'b1], mem_reg[lo]}
                      : {8'h00, mem_reg[lo]};
    endfunction : fetch

    ////////////////////////////////////////////////////////////////
    // Core state
    typedef struct packed
    {
        see_state_t state;
        logic sel_d;
        logic clk_d;
        logic words;
        logic [1:0] op;
        logic [BAW-1:0] addr;
        logic [4:0] cnt;
        logic [15:0] shreg;
        logic unlocked;
        logic [PCW-1:0] timer;
        logic prog_all;
        logic [BAW-1:0] prog_addr;
        logic [15:0] prog_data;
        logic prog_go;
        logic dout;
        logic oe;
        logic busy_out;
    } see_core_st_t;

    see_core_st_t st_reg;
    see_core_st_t st_next;

    logic clk_rise;
    logic clk_fall;
    logic sel_rise;
    logic busy;

    assign clk_rise = clk_s & ~st_reg.clk_d;
    assign clk_fall = ~clk_s & st_reg.clk_d;
    assign sel_rise = sel_s & ~st_reg.sel_d;
    assign busy = (st_reg.timer != '0);

    // Instruction sequencer and programming timer
    always_comb
    begin
        st_next = st_reg;
        st_next.sel_d = sel_s;
        st_next.clk_d = clk_s;
        st_next.prog_go = 1'b0;
        // Timer runs on the system clock alone, so a stopped serial
        // clock cannot stall or corrupt programming
        if (busy)
        begin
            st_next.timer = st_reg.timer - 1'b1;
            st_next.prog_go = (st_reg.timer == PCW'(1));
        end
        if (!sel_s)
        begin
            // Deselect aborts any instruction; output released
            st_next.state = SEE_IDLE;
            st_next.oe = 1'b0;
        end
        else
        begin
            unique case (st_reg.state)
                SEE_IDLE:
                begin
                    // Select rise with clock low opens an instruction
                    if (sel_rise && !clk_s)
                    begin
                        st_next.state = SEE_WAIT;
                    end
                end
                SEE_WAIT:
                begin
                    // Busy/ready shown while programming; start bit
                    // of one is refused until programming ends
                    st_next.oe = busy | st_reg.oe;
                    st_next.dout = ~busy;
                    if (clk_rise && din_s && !busy)
                    begin
                        st_next.state = SEE_OPCODE;
                        st_next.oe = 1'b0;
                        st_next.cnt = 5'h0;
                        st_next.words = wsel_s;
                    end
                end
                SEE_OPCODE:
                begin
                    if (clk_rise)
                    begin
                        st_next.op = {st_reg.op[0], din_s};
                        st_next.cnt = st_reg.cnt + 1'b1;
                        if (st_reg.cnt == 5'h1)
                        begin
                            st_next.state = SEE_ADDR;
                            st_next.cnt = 5'h0;
                            st_next.addr = '0;
                        end
                    end
                end
                SEE_ADDR:
                begin
                    if (clk_rise)
                    begin
                        st_next.addr = {st_reg.addr[BAW-2:0], din_s};
                        st_next.cnt = st_reg.cnt + 1'b1;
                        if (st_reg.cnt == addr_len(st_reg.words) - 1'b1)
                        begin
                            st_next.cnt = 5'h0;
                            st_next.state = SEE_IDLE;
                            st_next.shreg = SEE_ERASED;
                            // Top two address bits of the extended op
                            unique case (st_reg.op)
                                SEE_OP_READ:
                                begin
                                    // Dummy zero now; first location is
                                    // preloaded so its MSB follows next
                                    st_next.state = SEE_READ;
                                    st_next.oe = 1'b1;
                                    st_next.dout = 1'b0;
                                    st_next.shreg = fetch(st_reg.words,
                                        {st_reg.addr[BAW-2:0], din_s});
                                    st_next.cnt = st_reg.words ? 5'hF
                                                               : 5'h7;
                                end
                                SEE_OP_WRITE:
                                begin
                                    st_next.state = SEE_DATA;
                                end
                                SEE_OP_ERASE:
                                begin
                                    if (st_reg.unlocked)
                                    begin
                                        st_next.prog_all = 1'b0;
                                        st_next.prog_addr =
                                            {st_reg.addr[BAW-2:0], din_s};
                                        st_next.prog_data = SEE_ERASED;
                                        st_next.timer = PCW'(PROG_CYCLES);
                                        st_next.state = SEE_WAIT;
                                    end
                                end
                                SEE_OP_EXT:
                                begin
                                    unique case (st_reg.words
                                        ? st_reg.addr[WAW-2 -: 2]
                                        : st_reg.addr[BAW-2 -: 2])
                                        SEE_EXT_UNLOCK:
                                            st_next.unlocked = 1'b1;
                                        SEE_EXT_LOCK:
                                            st_next.unlocked = 1'b0;
                                        SEE_EXT_BULK_ERASE:
                                        begin
                                            if (st_reg.unlocked)
                                            begin
                                                st_next.prog_all = 1'b1;
                                                st_next.prog_data =
                                                    SEE_ERASED;
                                                st_next.timer =
                                                    PCW'(PROG_CYCLES);
                                                st_next.state = SEE_WAIT;
                                            end
                                        end
                                        SEE_EXT_FILL:
                                            st_next.state = SEE_DATA;
                                    endcase
                                end
                            endcase
                            // Last address bit completes the register
                            st_next.addr = {st_reg.addr[BAW-2:0], din_s};
                        end
                    end
                end
                SEE_DATA:
                begin
                    // One location of data, then the programming starts if unlocked
                    if (clk_rise)
                    begin
                        st_next.shreg = {st_reg.shreg[14:0], din_s};
                        st_next.cnt = st_reg.cnt + 1'b1;
                        if (st_reg.cnt == (st_reg.words ? 5'hF : 5'h7))
                        begin
                            st_next.state = SEE_IDLE;
                            if (st_reg.unlocked)
                            begin
                                st_next.prog_all = (st_reg.op == SEE_OP_EXT);
                                st_next.prog_addr = st_reg.addr;
                                st_next.prog_data =
                                    {st_reg.shreg[14:0], din_s};
                                st_next.timer = PCW'(PROG_CYCLES);
                                st_next.state = SEE_WAIT;
                            end
                        end
                    end
                end
                SEE_READ:
                begin
                    // Data MSB first, one bit after each clock rise
                    if (clk_rise)
                    begin
                        st_next.dout = st_reg.shreg[st_reg.cnt[3:0]];
                        if (st_reg.cnt == 5'h0)
                        begin
                            // Increment with natural wrap past the top
                            st_next.addr = st_reg.addr + 1'b1;
                            if (st_reg.words)
                            begin
                                st_next.addr[BAW-1] = 1'b0;
                            end
                            st_next.shreg = fetch(st_reg.words,
                                                  st_next.addr);
                            st_next.cnt = st_reg.words ? 5'hF : 5'h7;
                        end
                        else
                        begin
                            st_next.cnt = st_reg.cnt - 1'b1;
                        end
                    end
                end
                default:
                begin
                    st_next.state = SEE_IDLE;
                end
            endcase
        end
        if (clk_fall)
        begin
            st_next.clk_d = clk_s;
        end
        // Busy flag registered beside the timer it mirrors
        st_next.busy_out = (st_next.timer != '0);
    end

    // State register; reset is the power-on reset, device starts locked
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Array commit at the end of the programming time; the new value
    // replaces the old outright, which covers the automatic erase
    always_ff @(posedge i_mclk)
    begin
        if (st_reg.prog_go)
        begin
            for (int i = 0; i < BYTES; i++)
            begin
                if (st_reg.prog_all
                    || (st_reg.words && BAW'(i >> 1) ==
                        {1'b0, st_reg.prog_addr[BAW-2:0]})
                    || (!st_reg.words && BAW'(i) == st_reg.prog_addr))
                begin
                    mem_reg[i] <= (st_reg.words && i[0])
                        ? st_reg.prog_data[15:8]
                        : st_reg.prog_data[7:0];
                end
            end
        end
    end

    // Outputs straight from flip-flops
    assign o_sdata = st_reg.dout;
    assign o_sdata_oe = st_reg.oe;
    assign o_busy = st_reg.busy_out;
endmodule : see_core
`default_nettype wire

// ### sim/see_core_monitor.sv
// Port checker for the serial EEPROM access core
`timescale 1ns/100ps
`default_nettype none
module see_core_monitor
#(
    parameter int ARRAY_BITS = 16384,
    parameter int PROG_CYCLES = 100000
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Serial pins and busy status
    input wire logic i_select,
    input wire logic i_sclk,
    input wire logic i_sdata,
    input wire logic i_width_select,
    input wire logic o_sdata,
    input wire logic o_sdata_oe,
    input wire logic o_busy
);
    int busy_cnt_reg;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // Length of the current programming run, checked against the timer
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= o_busy ? busy_cnt_reg + 1 : 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Pin sync latency is a few clocks, so eight cycles of margin
    reset_exit_quiet_a: assert property ($fell(i_sys_rst) |->
        !o_sdata_oe && !o_busy) else $error("active right after reset");
    deselect_hiz_a: assert property (!i_select [*8] |->
        !o_sdata_oe) else $error("output driven while deselected");
    oe_needs_select_a: assert property ($rose(o_sdata_oe) |->
        i_select) else $error("output enabled without select");
    oe_holds_a: assert property (o_sdata_oe && i_select |=>
        o_sdata_oe) else $error("output dropped while selected");
    busy_max_a: assert property (o_busy |->
        busy_cnt_reg <= PROG_CYCLES) else $error("programming too long");
    busy_min_a: assert property ($fell(o_busy) |->
        busy_cnt_reg >= PROG_CYCLES - 1) else $error("programming short");
    busy_low_a: assert property ((o_busy [*3]) ##0 o_sdata_oe |->
        !o_sdata) else $error("busy not shown as low");
    busy_oe_a: assert property ((o_busy && i_select) [*8] |->
        o_sdata_oe) else $error("busy status not driven");
    ready_high_a: assert property ($fell(o_busy) && o_sdata_oe |->
        ##[0:4] (o_sdata || !o_sdata_oe)) else $error("ready not shown");
    dout_stable_a: assert property
        ((!i_sclk && !o_busy && i_select) [*8] ##0 o_sdata_oe |=>
        $stable(o_sdata)) else $error("output moved without clock");
endmodule : see_core_monitor
bind see_core see_core_monitor #(
    .ARRAY_BITS(ARRAY_BITS),
    .PROG_CYCLES(PROG_CYCLES)
) u_mon (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_select(i_select),
    .i_sclk(i_sclk), .i_sdata(i_sdata), .i_width_select(i_width_select),
    .o_sdata(o_sdata), .o_sdata_oe(o_sdata_oe), .o_busy(o_busy)
);
`default_nettype wire

// ### sim/see_master_model.sv
// Bus master model driving select, serial clock and serial data
`timescale 1ns/100ps
`default_nettype none
module see_master_model
(
    // Clock
    input wire logic i_mclk,
    // Device output and its enable
    input wire logic i_dout,
    input wire logic i_dout_oe,
    // Pins towards the device
    output logic o_select,
    output logic o_sclk,
    output logic o_sdo
);
    logic last_q = 1'b0;
    logic line;
    ////////////////////////////////////////////////////////////////////////
    // A released line shows the inverse of its last level, never a copy
    always @(posedge i_mclk)
    begin
        if (i_dout_oe)
            last_q <= i_dout;
    end
    assign line = i_dout_oe ? i_dout : ~last_q;
    // Select low from power-up, serial clock still outside frames
    initial
    begin
        o_select = 1'b0;
        o_sclk = 1'b0;
        o_sdo = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Only one device is selected, and only while the clock is low
    task automatic frame_on();
        @(posedge i_mclk);
        o_select <= 1'b1;
    endtask : frame_on
    task automatic frame_off();
        @(posedge i_mclk);
        o_select <= 1'b0;
        o_sdo <= ~o_sdo;
        repeat (10) @(posedge i_mclk);
    endtask : frame_off
    // Phases of 8 clocks stay clear of the pin sync latency
    task automatic clk_bit(input logic d);
        @(posedge i_mclk);
        o_sdo <= d;
        repeat (8) @(posedge i_mclk);
        o_sclk <= 1'b1;
        repeat (8) @(posedge i_mclk);
        o_sclk <= 1'b0;
        @(posedge i_mclk);
    endtask : clk_bit
    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            clk_bit(v[i]);
    endtask : send
    task automatic fetch(input int n, output logic [15:0] v);
        v = 16'h0000;
        for (int i = 0; i < n; i++)
        begin
            clk_bit(~o_sdo);
            v = {v[14:0], line};
        end
    endtask : fetch
endmodule : see_master_model
`default_nettype wire

// ### sim/test_serial_eeprom_access_core.sv
// Self-checking testbench of the serial EEPROM access core
`timescale 1ns/100ps
`default_nettype none
module test_serial_eeprom_access_core;
    import see_pkg::*;
    typedef struct packed {logic [9:0] addr; logic [15:0] data;} see_row_t;
    localparam int PROG = 200;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic width_sel = 1'b1;
    logic sel, sclk, sdi, dout, oe, busy;
    int err_count = 0;
    int tests_run = 0;
    logic [15:0] mem_q [1024];
    see_row_t rows [4] = '{'{10'h3FF, 16'h5A5A}, '{10'h000, 16'h1234},
                           '{10'h001, 16'hABCD}, '{10'h002, 16'hC3C3}};
    ////////////////////////////////////////////////////////////////////////
    // 20 MHz clock, short programming timer to keep the run brief
    always #25 i_mclk = ~i_mclk;
    see_core #(.PROG_CYCLES(PROG)) dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_select(sel),
        .i_sclk(sclk), .i_sdata(sdi), .i_width_select(width_sel),
        .o_sdata(dout), .o_sdata_oe(oe), .o_busy(busy));
    see_master_model m (.i_mclk(i_mclk), .i_dout(dout), .i_dout_oe(oe),
        .o_select(sel), .o_sclk(sclk), .o_sdo(sdi));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick
    // Expected data from the array model, byte halves in byte mode
    function automatic logic [15:0] exp_of(input logic [10:0] a);
        logic [15:0] w;
        w = mem_q[width_sel ? a[9:0] : a[10:1]];
        if (width_sel)
            return w;
        return {8'h00, a[0] ? w[15:8] : w[7:0]};
    endfunction : exp_of
    task automatic put(input logic [10:0] a, input logic [15:0] d);
        if (width_sel)
            mem_q[a[9:0]] = d;
        else if (a[0])
            mem_q[a[10:1]][15:8] = d[7:0];
        else
            mem_q[a[10:1]][7:0] = d[7:0];
    endtask : put
    function automatic logic [10:0] ext_a(input logic [1:0] c);
        return width_sel ? {1'b0, c, 8'h00} : {c, 9'h000};
    endfunction : ext_a
    // Header: start bit, opcode, then 10 or 11 address bits
    task automatic cmd(input logic [1:0] op, input logic [10:0] a);
        m.frame_on();
        if (width_sel)
            m.send({1'b1, op, a[9:0]}, 13);
        else
            m.send({1'b1, op, a}, 14);
    endtask : cmd
    task automatic ext(input logic [1:0] c);
        cmd(SEE_OP_EXT, ext_a(c));
        m.frame_off();
    endtask : ext
    // Programming op; ok tells whether a timed cycle must follow
    task automatic prog(input logic [1:0] op, input logic [10:0] a,
        input logic [15:0] d, input int nd, input logic ok);
        int t;
        cmd(op, a);
        if (nd > 0)
            m.send(d, nd);
        tick(10);
        check("busy", busy, ok);
        if (ok)
        begin
            check("busy_state", {oe, dout}, 2'b10);
            for (t = 0; t < 400 && busy === 1'b1; t++)
                tick(1);
            if (t >= 400)
            begin
                err_count++;
                report_and_stop();
            end
            tick(6);
            check("ready_state", {oe, dout}, 2'b11);
        end
        m.frame_off();
        check("hiz", oe, 1'b0);
    endtask : prog
    task automatic rd(input logic [10:0] a, input int n);
        logic [15:0] v;
        cmd(SEE_OP_READ, a);
        check("dummy", {oe, dout}, 2'b10);
        for (int i = 0; i < n; i++)
        begin
            m.fetch(width_sel ? 16 : 8, v);
            check("rdata", v, exp_of(a + 11'(i)));
        end
        m.frame_off();
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // Main sequence; all seven instructions are used below
    initial
    begin
        tick(6);
        i_sys_rst <= 1'b0;
        tick(8);
        check("reset_state", {oe, busy}, 2'b00);
        prog(SEE_OP_WRITE, 11'h005, 16'h1111, 16, 1'b0);
        ext(SEE_EXT_UNLOCK);
        foreach (rows[i])
        begin
            prog(SEE_OP_WRITE, rows[i].addr, rows[i].data, 16, 1'b1);
            put(rows[i].addr, rows[i].data);
            rd(rows[i].addr, 1);
        end
        rd(11'h3FF, 3);
        prog(SEE_OP_ERASE, 11'h000, 16'h0000, 0, 1'b1);
        put(11'h000, SEE_ERASED);
        rd(11'h000, 2);
        prog(SEE_OP_EXT, ext_a(SEE_EXT_FILL), 16'h0F0F, 16, 1'b1);
        foreach (mem_q[k])
            mem_q[k] = 16'h0F0F;
        rd(11'h1F4, 1);
        prog(SEE_OP_EXT, ext_a(SEE_EXT_BULK_ERASE), 16'h0, 0, 1'b1);
        foreach (mem_q[k])
            mem_q[k] = SEE_ERASED;
        rd(11'h3FF, 2);
        // Byte mode, then the same word seen whole
        width_sel <= 1'b0;
        prog(SEE_OP_WRITE, 11'h001, 16'h0077, 8, 1'b1);
        put(11'h001, 16'h0077);
        rd(11'h000, 2);
        width_sel <= 1'b1;
        rd(11'h000, 1);
        ext(SEE_EXT_LOCK);
        prog(SEE_OP_WRITE, 11'h002, 16'h2222, 16, 1'b0);
        rd(11'h002, 1);
        // Reset in mid-programming, with an unlock sent while it is held
        ext(SEE_EXT_UNLOCK);
        cmd(SEE_OP_WRITE, 11'h003);
        m.send(16'h3333, 16);
        tick(20);
        i_sys_rst <= 1'b1;
        tick(2);
        check("reset_again", {oe, busy}, 2'b00);
        m.frame_off();
        ext(SEE_EXT_UNLOCK);
        i_sys_rst <= 1'b0;
        tick(8);
        prog(SEE_OP_WRITE, 11'h004, 16'h4444, 16, 1'b0);
        // The write cut by reset must leave its location untouched
        rd(11'h003, 1);
        report_and_stop();
    end
endmodule : test_serial_eeprom_access_core
`default_nettype wire
